//--- logic/bus_strobe_pkg.sv
package bus_strobe_pkg;

	// ----------------------------------------
	// Bus states and cycle kinds
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_TW,
		ST_T4
	} bus_state_type;

	typedef enum logic [1:0] {
		KIND_READ,
		KIND_WRITE,
		KIND_IRQ_ACK
	} cycle_kind_type;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic is_io;
		cycle_kind_type kind;
	} cycle_req_type;

	typedef struct packed {
		logic io_mem_sel;
		logic write_strobe_n;
		logic read_strobe_n;
		logic irq_ack_strobe_n;
		logic addr_latch;
		logic xcvr_direction;
		logic xcvr_enable_n;
	} strobe_set_type;

	// Idle values of the outputs, also the hold-released resting level
	localparam logic IDLE_HIGH = 1'h1;
	localparam logic IDLE_LOW = 1'h0;

endpackage : bus_strobe_pkg

//--- logic/half_phase_gen.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Falling-edge retime of a level
// ----------------------------------------
// Delays a level by half a clock so strobes can start or end mid-state.
module half_phase_gen (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic level_i,
	output logic level_o
);

	logic next_level;

	// Pass-through on the falling edge
	always_comb begin
		next_level = level_i;
	end

	always_ff @(negedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level_o <= 1'h0;
		end else begin
			level_o <= next_level;
		end
	end

endmodule : half_phase_gen

`default_nettype wire

//--- logic/tristate_rest_one.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Released pin that rests at logic one
// ----------------------------------------
// Output enable is low while driving; while released the output is held
// at one so the bus keeper sees a defined high level.
module tristate_rest_one (
	input wire logic release_i,
	input wire logic value_i,
	output logic pin_o,
	output logic pin_oe_n_o
);

	// Drive or rest high
	always_comb begin
		pin_oe_n_o = release_i;
		pin_o = release_i ? bus_strobe_pkg::IDLE_HIGH : value_i;
	end

endmodule : tristate_rest_one

`default_nettype wire

//--- logic/min_mode_bus_control_strobes.sv
// Notes on behaviour
// [RULE1] Strobe outputs act only when the mode pin is high, else rest idle; here the pin gates only taking a cycle and granting hold.
// [RULE2] The select output is high for I/O and low for memory.
// [RULE3] The select is valid from the T4 before a cycle to its final T4; here it changes only on the edge that starts T1.
// [RULE4] In hold, select, write, direction and enable float resting at one.
// [RULE5] The write strobe appears only in write cycles.
// [RULE6] The write strobe is low in T2, T3 and every wait state of a write.
// [RULE7] The interrupt strobe is low in T2, T3 and wait states of its cycle.
// [RULE8] The latch pulse is high-going and is never released.
// [RULE9] Direction is high to transmit and low to receive.
// [RULE10] Direction has the same timing as the select output.
// [RULE11] The transceiver enable is low during every bus cycle.
// [RULE12] For reads and acknowledges the enable spans mid T2 to mid T4.
// [RULE13] For writes the enable spans start of T2 to mid T4.
// [RULE14] The read strobe is low in T2, T3 and every wait state of a read.
// [RULE15] Ready from the far device ends wait states; absent, Tw repeats.
// [RULE16] Hold is granted mid T4 or T1 and the bus floats until released; here the grant rises on the clock edge that ends idle or T4.
// [RULE17] One latch pulse is issued in T1 of each bus cycle.
`timescale 1ns/1ns
`default_nettype none

module min_mode_bus_control_strobes (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic config_mode_pin_i,
	input wire bus_strobe_pkg::cycle_req_type req_i,
	input wire logic ready_i,
	input wire logic hold_req_i,
	output logic req_taken_o,
	output logic cycle_done_o,
	output logic hold_grant_o,
	output logic io_mem_sel_o,
	output logic io_mem_sel_oe_n_o,
	output logic write_strobe_n_o,
	output logic write_strobe_oe_n_o,
	output logic read_strobe_n_o,
	output logic irq_ack_strobe_n_o,
	output logic addr_latch_o,
	output logic xcvr_direction_o,
	output logic xcvr_direction_oe_n_o,
	output logic xcvr_enable_n_o,
	output logic xcvr_enable_oe_n_o,
	output logic max_status_bit2_o,
	output logic max_status_bit1_o
);

	// ----------------------------------------
	// Bus sequencer state
	// ----------------------------------------
	bus_strobe_pkg::bus_state_type state;
	bus_strobe_pkg::bus_state_type next_state;
	bus_strobe_pkg::cycle_req_type cur;
	bus_strobe_pkg::cycle_req_type next_cur;
	logic hold_grant;
	logic next_hold_grant;
	bus_strobe_pkg::strobe_set_type strobe;
	bus_strobe_pkg::strobe_set_type next_strobe;
	logic en_rise_level;
	logic en_fall_level;
	logic en_mid;
	logic en_mid_end;

	// Boundary state: idle or T4, where a new cycle may be prepared
	function automatic logic at_boundary(
		input bus_strobe_pkg::bus_state_type s
	);
		at_boundary = (s == bus_strobe_pkg::ST_IDLE) ||
			(s == bus_strobe_pkg::ST_T4);
	endfunction : at_boundary

	// Strobe window T2, T3, Tw
	function automatic logic in_data_phase(
		input bus_strobe_pkg::bus_state_type s
	);
		in_data_phase = (s == bus_strobe_pkg::ST_T2) ||
			(s == bus_strobe_pkg::ST_T3) ||
			(s == bus_strobe_pkg::ST_TW);
	endfunction : in_data_phase

	// Request taken only in a boundary state with no hold pending
	// [RULE1] minimum mode gate
	assign req_taken_o = config_mode_pin_i && req_i.valid &&
		at_boundary(state) && !hold_req_i && !hold_grant;
	assign cycle_done_o = (state == bus_strobe_pkg::ST_T4);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_hold_grant = hold_grant;
		case (state)
			bus_strobe_pkg::ST_IDLE,
			bus_strobe_pkg::ST_T4: begin
				// [RULE16] grant only between cycles
				if (hold_req_i && config_mode_pin_i) begin
					next_hold_grant = 1'h1;
					next_state = bus_strobe_pkg::ST_IDLE;
					next_cur.valid = 1'h0;
				end else if (!hold_req_i) begin
					next_hold_grant = 1'h0;
					if (req_taken_o) begin
						next_cur = req_i;
						next_state = bus_strobe_pkg::ST_T1;
					end else begin
						next_state = bus_strobe_pkg::ST_IDLE;
						next_cur.valid = 1'h0;
					end
				end
			end
			bus_strobe_pkg::ST_T1: begin
				next_state = bus_strobe_pkg::ST_T2;
			end
			bus_strobe_pkg::ST_T2: begin
				next_state = bus_strobe_pkg::ST_T3;
			end
			bus_strobe_pkg::ST_T3,
			bus_strobe_pkg::ST_TW: begin
				// [RULE15] wait states until ready
				next_state = ready_i ? bus_strobe_pkg::ST_T4 :
					bus_strobe_pkg::ST_TW;
			end
			default: begin
				next_state = bus_strobe_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= bus_strobe_pkg::ST_IDLE;
			cur <= '0;
			hold_grant <= 1'h0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			hold_grant <= next_hold_grant;
		end
	end

	// ----------------------------------------
	// Registered strobe values
	// ----------------------------------------
	// Computed from the next state so each strobe changes on the edge that
	// enters its state, with no combinational glitch on the pins.
	always_comb begin
		next_strobe.io_mem_sel = strobe.io_mem_sel;
		next_strobe.xcvr_direction = strobe.xcvr_direction;
		next_strobe.write_strobe_n = bus_strobe_pkg::IDLE_HIGH;
		next_strobe.read_strobe_n = bus_strobe_pkg::IDLE_HIGH;
		next_strobe.irq_ack_strobe_n = bus_strobe_pkg::IDLE_HIGH;
		next_strobe.addr_latch = bus_strobe_pkg::IDLE_LOW;
		next_strobe.xcvr_enable_n = bus_strobe_pkg::IDLE_HIGH;
		// [RULE3] select and direction computed in the T4 or idle, loaded on the edge into T1
		if (req_taken_o) begin
			// [RULE2] high for I/O
			next_strobe.io_mem_sel = req_i.is_io;
			// [RULE9] transmit only on writes
			next_strobe.xcvr_direction =
				(req_i.kind == bus_strobe_pkg::KIND_WRITE);
		end
		// [RULE17] one latch pulse in T1
		if (next_state == bus_strobe_pkg::ST_T1) begin
			next_strobe.addr_latch = 1'h1;
		end
		if (in_data_phase(next_state) && next_cur.valid) begin
			case (next_cur.kind)
				bus_strobe_pkg::KIND_WRITE: begin
					// [RULE5] [RULE6] write strobe window
					next_strobe.write_strobe_n = 1'h0;
				end
				bus_strobe_pkg::KIND_IRQ_ACK: begin
					// [RULE7] acknowledge strobe window
					next_strobe.irq_ack_strobe_n = 1'h0;
				end
				default: begin
					// [RULE14] read strobe window
					next_strobe.read_strobe_n = 1'h0;
				end
			endcase
		end
		// [RULE13] write enable from start of T2
		if (in_data_phase(next_state) && next_cur.valid &&
			next_cur.kind == bus_strobe_pkg::KIND_WRITE) begin
			next_strobe.xcvr_enable_n = 1'h0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe <= '{
				io_mem_sel: bus_strobe_pkg::IDLE_LOW,
				write_strobe_n: bus_strobe_pkg::IDLE_HIGH,
				read_strobe_n: bus_strobe_pkg::IDLE_HIGH,
				irq_ack_strobe_n: bus_strobe_pkg::IDLE_HIGH,
				addr_latch: bus_strobe_pkg::IDLE_LOW,
				xcvr_direction: bus_strobe_pkg::IDLE_LOW,
				xcvr_enable_n: bus_strobe_pkg::IDLE_HIGH
			};
		end else begin
			strobe <= next_strobe;
		end
	end

	// ----------------------------------------
	// Mid-state enable edges
	// ----------------------------------------
	// Start level is T2..T4 of a read or acknowledge cycle; falling-edge copy begins mid T2.
	// End is a falling-edge copy of the data window T2, T3, Tw only, ending mid T4.
	assign en_rise_level = cur.valid && (in_data_phase(state) ||
		state == bus_strobe_pkg::ST_T4) &&
		cur.kind != bus_strobe_pkg::KIND_WRITE;
	assign en_fall_level = cur.valid && in_data_phase(state);

	half_phase_gen u_en_start (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.level_i(en_rise_level),
		.level_o(en_mid)
	);

	half_phase_gen u_en_end (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.level_i(en_fall_level),
		.level_o(en_mid_end)
	);

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	logic xcvr_enable_n_comb;

	// [RULE11] [RULE12] read and acknowledge: mid T2 to mid T4
	always_comb begin
		xcvr_enable_n_comb = strobe.xcvr_enable_n;
		if (en_mid && en_mid_end && cur.kind != bus_strobe_pkg::KIND_WRITE) begin
			xcvr_enable_n_comb = 1'h0;
		end
		// [RULE13] write enable extends to mid T4
		if (state == bus_strobe_pkg::ST_T4 && en_mid_end && cur.valid &&
			cur.kind == bus_strobe_pkg::KIND_WRITE) begin
			xcvr_enable_n_comb = 1'h0;
		end
	end

	// [RULE4] released pins rest at one during hold
	tristate_rest_one u_pin_sel (
		.release_i(hold_grant),
		.value_i(strobe.io_mem_sel),
		.pin_o(io_mem_sel_o),
		.pin_oe_n_o(io_mem_sel_oe_n_o)
	);
	tristate_rest_one u_pin_wr (
		.release_i(hold_grant),
		.value_i(strobe.write_strobe_n),
		.pin_o(write_strobe_n_o),
		.pin_oe_n_o(write_strobe_oe_n_o)
	);
	// [RULE10] direction shares the select timing
	tristate_rest_one u_pin_dir (
		.release_i(hold_grant),
		.value_i(strobe.xcvr_direction),
		.pin_o(xcvr_direction_o),
		.pin_oe_n_o(xcvr_direction_oe_n_o)
	);
	tristate_rest_one u_pin_en (
		.release_i(hold_grant),
		.value_i(xcvr_enable_n_comb),
		.pin_o(xcvr_enable_n_o),
		.pin_oe_n_o(xcvr_enable_oe_n_o)
	);

	// [RULE8] latch output always driven
	assign addr_latch_o = strobe.addr_latch;
	assign read_strobe_n_o = strobe.read_strobe_n;
	assign irq_ack_strobe_n_o = strobe.irq_ack_strobe_n;
	assign hold_grant_o = hold_grant;
	// Status equivalents: bit2 inverse of select, bit1 equals direction
	assign max_status_bit2_o = ~strobe.io_mem_sel;
	assign max_status_bit1_o = strobe.xcvr_direction;

endmodule : min_mode_bus_control_strobes

`default_nettype wire

//--- testbench/ready_source.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Addressed device answering with ready
// ----------------------------------------
module ready_source (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic access_n_i,
	input wire logic [3:0] wait_count_i,
	output logic ready_o
);
	logic [3:0] held;
	logic [3:0] next_held;

	// Cycles spent with a strobe low
	always_comb begin
		next_held = access_n_i ? 4'h0 : held + 4'h1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			held <= 4'h0;
		end else begin
			held <= next_held;
		end
	end

	// ready after waits
	// Unselected device says not ready rather than a stale high
	assign ready_o = !access_n_i && (held > wait_count_i);
endmodule : ready_source
`default_nettype wire

//--- testbench/min_mode_bus_control_strobes_checker.sv
`timescale 1ns/1ns
`default_nettype none

module min_mode_bus_control_strobes_checker (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic config_mode_pin_i,
	input wire bus_strobe_pkg::cycle_req_type req_i,
	input wire logic hold_req_i,
	input wire logic req_taken_o,
	input wire logic cycle_done_o,
	input wire logic hold_grant_o,
	input wire logic io_mem_sel_o,
	input wire logic io_mem_sel_oe_n_o,
	input wire logic write_strobe_n_o,
	input wire logic write_strobe_oe_n_o,
	input wire logic read_strobe_n_o,
	input wire logic irq_ack_strobe_n_o,
	input wire logic addr_latch_o,
	input wire logic xcvr_direction_o,
	input wire logic xcvr_direction_oe_n_o,
	input wire logic xcvr_enable_n_o,
	input wire logic xcvr_enable_oe_n_o,
	input wire logic max_status_bit2_o,
	input wire logic max_status_bit1_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// Kind of the request on offer
	logic is_wr;
	assign is_wr = req_i.kind == bus_strobe_pkg::KIND_WRITE;

	// Accepted request followed by its T1 latch pulse
	sequence s_open_wr;
		req_taken_o && is_wr ##1 addr_latch_o;
	endsequence
	sequence s_open_rd;
		req_taken_o && !is_wr ##1 addr_latch_o;
	endsequence

	a_take_gated: assert property (!config_mode_pin_i |-> !req_taken_o)
		else $error("cycle accepted with mode pin low");
	a_status_copy: assert property (!hold_grant_o |->
		max_status_bit2_o != io_mem_sel_o && max_status_bit1_o == xcvr_direction_o)
		else $error("status copies disagree");
	a_select_load: assert property (req_taken_o |=>
		io_mem_sel_o == $past(req_i.is_io) && xcvr_direction_o == $past(is_wr))
		else $error("select or direction not loaded");
	a_select_hold: assert property (!req_taken_o && !hold_req_i &&
		!hold_grant_o |=> $stable(io_mem_sel_o) && $stable(xcvr_direction_o))
		else $error("select moved inside a cycle");
	a_hold_float: assert property (hold_grant_o |-> !req_taken_o &&
		&{io_mem_sel_oe_n_o, write_strobe_oe_n_o, xcvr_direction_oe_n_o,
		xcvr_enable_oe_n_o, io_mem_sel_o, write_strobe_n_o, xcvr_direction_o,
		xcvr_enable_n_o}) else $error("bus not released in hold");
	a_latch_once: assert property (req_taken_o |=>
		addr_latch_o ##1 !addr_latch_o[*3]) else $error("latch pulse wrong");
	a_write_open: assert property (s_open_wr |=>
		!write_strobe_n_o && !xcvr_enable_n_o) else $error("write T2 wrong");
	a_read_open: assert property (s_open_rd |=> write_strobe_n_o &&
		!xcvr_enable_n_o && !(read_strobe_n_o && irq_ack_strobe_n_o))
		else $error("read T2 wrong");
	a_strobe_close: assert property ($rose(write_strobe_n_o) ||
		$rose(read_strobe_n_o) || $rose(irq_ack_strobe_n_o) |-> cycle_done_o)
		else $error("strobe ended outside T4");
	a_enable_close: assert property (cycle_done_o |->
		xcvr_enable_n_o && !addr_latch_o) else $error("enable held past T4");
endmodule : min_mode_bus_control_strobes_checker

bind min_mode_bus_control_strobes min_mode_bus_control_strobes_checker
	min_mode_bus_control_strobes_checker_i (.*);
`default_nettype wire

//--- testbench/min_mode_bus_control_strobes_test.sv
`timescale 1ns/1ns
`default_nettype none

module min_mode_bus_control_strobes_test;
	logic clk_i, nrst_i, config_mode_pin_i, ready_i, hold_req_i;
	bus_strobe_pkg::cycle_req_type req_i;
	logic req_taken_o, cycle_done_o, hold_grant_o, io_mem_sel_o;
	logic io_mem_sel_oe_n_o, write_strobe_n_o, write_strobe_oe_n_o;
	logic read_strobe_n_o, irq_ack_strobe_n_o, addr_latch_o;
	logic xcvr_direction_o, xcvr_direction_oe_n_o, xcvr_enable_n_o;
	logic xcvr_enable_oe_n_o, max_status_bit2_o, max_status_bit1_o;
	logic [3:0] wait_count;
	int bad_count, comparisons;

	min_mode_bus_control_strobes min_mode_bus_control_strobes_i (.*);
	ready_source ready_source_i (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.access_n_i(write_strobe_n_o & read_strobe_n_o & irq_ack_strobe_n_o),
		.wait_count_i(wait_count),
		.ready_o(ready_i)
	);

	always #20 clk_i = ~clk_i;

	task check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task summarize;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// Walk one cycle to its T4, sampling mid low phase so half-state
	// enables are seen after they settle
	task run_cycle(input bus_strobe_pkg::cycle_req_type nxt,
		input logic [3:0] waits);
		bus_strobe_pkg::cycle_req_type cur;
		logic [7:0] wr, rd, ia, en, lat, exp;
		logic w, r, a;
		int n;
		cur = req_i;
		w = cur.kind === bus_strobe_pkg::KIND_WRITE;
		r = cur.kind === bus_strobe_pkg::KIND_READ;
		a = cur.kind === bus_strobe_pkg::KIND_IRQ_ACK;
		wait_count = waits;
		exp = 8'(waits) + 8'h2;
		{wr, rd, ia, en, lat} = '0;
		n = 0;
		while (req_taken_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			#10;
			n++;
		end
		// Request never taken: count it and stop rather than run on
		if (n >= 20) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time,
				8'(req_taken_o), 8'h1);
			summarize();
		end
		@(negedge clk_i);
		req_i = nxt;
		#10;
		check(8'(addr_latch_o), 8'h1);
		check(8'(io_mem_sel_o), 8'(cur.is_io));
		check(8'(xcvr_direction_o), 8'(w));
		while (cycle_done_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			#10;
			n++;
			wr += 8'(write_strobe_n_o === 1'b0);
			rd += 8'(read_strobe_n_o === 1'b0);
			ia += 8'(irq_ack_strobe_n_o === 1'b0);
			en += 8'(xcvr_enable_n_o === 1'b0);
			lat += 8'(addr_latch_o === 1'b1);
		end
		if (n >= 40) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time,
				8'(cycle_done_o), 8'h1);
			summarize();
		end
		check(wr, w ? exp : 8'h0);
		check(rd, r ? exp : 8'h0);
		check(ia, a ? exp : 8'h0);
		check(en, exp);
		check(lat, 8'h0);
		check(8'(xcvr_enable_n_o), 8'h1);
		check(8'(io_mem_sel_o), 8'(cur.is_io));
		check(8'(req_taken_o), 8'(nxt.valid));
	endtask : run_cycle

	// Every kind to memory and I/O, back to back, some with waits
	task scen_cycles;
		bus_strobe_pkg::cycle_req_type q[7];
		for (int i = 0; i < 6; i++) begin
			q[i] = '{1'b1, 1'(i % 2), bus_strobe_pkg::cycle_kind_type'(i / 2)};
		end
		q[6] = '0;
		@(negedge clk_i);
		req_i = q[0];
		#10;
		for (int i = 0; i < 6; i++) begin
			run_cycle(q[i + 1], 4'(2 * (i % 2)));
		end
	endtask : scen_cycles

	// Hold refuses a pending write, floats the bus, then lets it run
	task scen_hold;
		@(negedge clk_i);
		hold_req_i = 1'b1;
		req_i = '{1'b1, 1'b0, bus_strobe_pkg::KIND_WRITE};
		#10;
		check(8'(req_taken_o), 8'h0);
		@(negedge clk_i);
		#10;
		check(8'(hold_grant_o), 8'h1);
		check({io_mem_sel_oe_n_o, write_strobe_oe_n_o, xcvr_direction_oe_n_o,
			xcvr_enable_oe_n_o, io_mem_sel_o, write_strobe_n_o,
			xcvr_direction_o, xcvr_enable_n_o}, 8'hFF);
		check(8'(addr_latch_o), 8'h0);
		check(8'(req_taken_o), 8'h0);
		@(negedge clk_i);
		hold_req_i = 1'b0;
		@(negedge clk_i);
		#10;
		check(8'(hold_grant_o), 8'h0);
		run_cycle('0, 4'h1);
	endtask : scen_hold

	// Mode strap low blocks both cycles and hold grants
	task scen_mode;
		@(negedge clk_i);
		config_mode_pin_i = 1'b0;
		hold_req_i = 1'b1;
		req_i = '{1'b1, 1'b1, bus_strobe_pkg::KIND_IRQ_ACK};
		@(negedge clk_i);
		#10;
		check(8'(req_taken_o), 8'h0);
		check(8'(hold_grant_o), 8'h0);
		@(negedge clk_i);
		config_mode_pin_i = 1'b1;
		hold_req_i = 1'b0;
		#10;
		run_cycle('0, 4'h0);
	endtask : scen_mode

	initial begin
		clk_i = 1'b0;
		nrst_i = 1'b0;
		config_mode_pin_i = 1'b1;
		hold_req_i = 1'b0;
		req_i = '0;
		wait_count = 4'h0;
		bad_count = 0;
		comparisons = 0;
		repeat (12) @(negedge clk_i);
		nrst_i = 1'b1;
		scen_cycles();
		scen_hold();
		scen_mode();
		summarize();
	end
endmodule : min_mode_bus_control_strobes_test
`default_nettype wire
